// ### lcd_host_link_model.sv
`timescale 1ns/1ps

module lcd_host_link_model (
	// Clock
	input  wire logic                        core_clk_i,
	// Serial link towards the device
	output lcd_loader_pkg::serial_in_t       serial_o
);
	initial begin
		serial_o = '0;
	end

	// ----------------------------------------------------------------
	// Frame transmit
	// ----------------------------------------------------------------
	// Sends f[first] up to f[45], pad ones ahead, then the strobe; stray
	// clocks during the strobe probe the device's lockout
	task automatic send(input logic [45:0] f, input int first, input int pad, input int stray);
		int i;
		for (i = 0; i < pad + 46 - first; i++) begin
			@(posedge core_clk_i);
			serial_o.serial_data <= (i < pad) ? 1'b1 : f[first + i - pad];
			serial_o.serial_clk  <= 1'b0;
			repeat (2) @(posedge core_clk_i);
			serial_o.serial_clk  <= 1'b1;
			repeat (2) @(posedge core_clk_i);
		end
		serial_o.serial_clk  <= 1'b0;
		// Released data line must not keep its last level
		serial_o.serial_data <= ~serial_o.serial_data;
		repeat (2) @(posedge core_clk_i);
		serial_o.load <= 1'b1;
		repeat (stray) begin
			repeat (2) @(posedge core_clk_i);
			serial_o.serial_clk <= 1'b1;
			repeat (2) @(posedge core_clk_i);
			serial_o.serial_clk <= 1'b0;
		end
		repeat (3) @(posedge core_clk_i);
		serial_o.load <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask
endmodule

// ### lcd_loader_cfg.svh
// Notes on behaviour
// - Serial data bit enters the shift register on each serial clock rise while the strobe is low.
// - While the strobe is high, segment data moves into the display latch.
// - Frame holds forty segment bits, two line-select bits and four command bits.
// - Command 0010 writes one of four common lines chosen by two low bits.
// - After reset every segment stays off until an unblank command.
// - Blank command 1010 forces all segments off, latched data kept.
// - Unblank command 1011 shows the latched content again.
// - Any other command leaves the latch untouched; shift contents still change.
// - Blank and unblank need only the four upper command bits shifted.
// - Command comes from the six bits held just before the strobe rises.
// - A segment write frame carries forty data bits plus six command bits.
// - Multiplex frame rate is the oscillator tick rate divided by 24.
`ifndef LCD_LOADER_CFG_SVH
`define LCD_LOADER_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define LCD_SEG_COUNT      40
`define LCD_COM_COUNT      4
`define LCD_CMD_WIDTH      6
`define LCD_CMD_POS        40

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCD_CORE_CLK_HZ    125000000
`define LCD_OSC_INT_HZ     10000
`define LCD_FRAME_DIV      24

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LCD_REG_CTRL       12'h000
`define LCD_REG_STATUS     12'h004
`define LCD_REG_SEG0       12'h010
`define LCD_CTRL_OSC_SEL   0
`define LCD_CTRL_RESET     1'h0
`define LCD_STAT_BLANK     0
`define LCD_STAT_COM_POS   4
`define LCD_STAT_CMD_POS   8

`endif

// ### lcd_loader_pkg.sv
package lcd_loader_pkg;

	typedef enum logic [3:0] {
		CMD_SEGMENT_WRITE = 4'h2,
		CMD_BLANK         = 4'hA,
		CMD_UNBLANK       = 4'hB
	} cmd_code_t;

	typedef struct packed {
		logic [3:0] code;
		logic [1:0] com;
	} cmd_field_t;

	typedef struct packed {
		logic serial_clk;
		logic serial_data;
		logic load;
	} serial_in_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// ### lcd_serial_command_loader.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "lcd_loader_cfg.svh"

module lcd_serial_command_loader #(
	parameter int SEG_COUNT = `LCD_SEG_COUNT,
	parameter int OSC_DIV   = `LCD_CORE_CLK_HZ / `LCD_OSC_INT_HZ
) (
	// Clock and reset
	input  wire logic                         core_clk_i,
	input  wire logic                         reset_n_i,
	// Serial host link
	input  wire lcd_loader_pkg::serial_in_t   serial_i,
	// External oscillator input
	input  wire logic                         osc_ext_i,
	// APB slave
	input  wire lcd_loader_pkg::apb_req_t     apb_i,
	output logic [31:0]                       prdata_o,
	output logic                              pready_o,
	output logic                              pslverr_o,
	// Display drive
	output logic [SEG_COUNT-1:0]              seg_o,
	output logic [`LCD_COM_COUNT-1:0]         com_o,
	output logic                              frame_tick_o
);

	localparam int SHIFT_W = SEG_COUNT + `LCD_CMD_WIDTH;
	localparam int DIV_W   = $clog2(OSC_DIV + 1);

	// ----------------------------------------------------------------
	// Edge detection of synchronous pin inputs
	// ----------------------------------------------------------------
	logic sclk_prev_q;
	logic load_prev_q;
	logic osc_prev_q;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			sclk_prev_q <= 1'b0;
			load_prev_q <= 1'b0;
			osc_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= serial_i.serial_clk;
			load_prev_q <= serial_i.load;
			osc_prev_q  <= osc_ext_i;
		end
	end

	wire sclk_rise = serial_i.serial_clk & ~sclk_prev_q;
	wire load_rise = serial_i.load & ~load_prev_q;
	// Edges while the strobe is high would corrupt the command being executed
	wire shift_en  = sclk_rise & ~serial_i.load & ~load_prev_q;

	// ----------------------------------------------------------------
	// Shift register
	// ----------------------------------------------------------------
	logic [SHIFT_W-1:0] shift_q;

	// Newest bit enters at the top, so the command ends at the top.
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			shift_q <= '0;
		end else if (shift_en) begin
			shift_q <= {serial_i.serial_data, shift_q[SHIFT_W-1:1]};
		end
	end

	// Short blank/unblank frames still land the code on top.
	wire lcd_loader_pkg::cmd_field_t cmd_field = shift_q[SHIFT_W-1 -: `LCD_CMD_WIDTH];
	wire [SEG_COUNT-1:0] seg_field = shift_q[SEG_COUNT-1:0];

	wire is_seg_write = cmd_field.code == lcd_loader_pkg::CMD_SEGMENT_WRITE;
	wire is_blank     = cmd_field.code == lcd_loader_pkg::CMD_BLANK;
	wire is_unblank   = cmd_field.code == lcd_loader_pkg::CMD_UNBLANK;

	// ----------------------------------------------------------------
	// Command execution, once per strobe rise
	// ----------------------------------------------------------------
	logic [`LCD_COM_COUNT-1:0][SEG_COUNT-1:0] seg_mem_q;
	logic                                     blanked_q;
	logic [`LCD_CMD_WIDTH-1:0]                last_cmd_q;

	genvar gi;
	generate
		for (gi = 0; gi < `LCD_COM_COUNT; gi++) begin : g_line
			wire hit = load_rise & is_seg_write & (cmd_field.com == 2'(gi));
			always_ff @(posedge core_clk_i) begin
				if (!reset_n_i) begin
					seg_mem_q[gi] <= '0;
				end else if (hit) begin
					seg_mem_q[gi] <= seg_field;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			blanked_q  <= 1'b1;
			last_cmd_q <= '0;
		end else if (load_rise) begin
			last_cmd_q <= cmd_field;
			if (is_blank) begin
				blanked_q <= 1'b1;
			end else if (is_unblank) begin
				blanked_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register and oscillator source
	// ----------------------------------------------------------------
	logic osc_sel_q;

	wire access    = apb_i.psel & apb_i.penable;
	wire setup     = apb_i.psel & ~apb_i.penable;
	wire hit_ctrl  = apb_i.paddr == `LCD_REG_CTRL;
	wire hit_stat  = apb_i.paddr == `LCD_REG_STATUS;
	wire [11:0] seg_off = apb_i.paddr - `LCD_REG_SEG0;
	// Segment readback: eight bytes per line, two words per line for 40 bits
	wire hit_seg   = (apb_i.paddr >= `LCD_REG_SEG0) && (seg_off < 12'h020)
		&& (apb_i.paddr[1:0] == 2'h0);
	wire [1:0] seg_line = seg_off[4:3];
	wire       seg_hi   = seg_off[2];
	wire addr_ok   = hit_ctrl | hit_stat | hit_seg;
	wire ctrl_wr   = access & apb_i.pwrite & hit_ctrl;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			osc_sel_q <= `LCD_CTRL_RESET;
		end else if (ctrl_wr) begin
			osc_sel_q <= apb_i.pwdata[`LCD_CTRL_OSC_SEL];
		end
	end

	// ----------------------------------------------------------------
	// Oscillator tick and frame multiplex
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_q;
	logic [4:0]       phase_q;
	logic [1:0]       com_idx_q;

	wire int_tick  = div_q == DIV_W'(OSC_DIV - 1);
	wire ext_tick  = osc_ext_i & ~osc_prev_q;
	wire osc_tick  = osc_sel_q ? ext_tick : int_tick;
	wire phase_end = phase_q == 5'(`LCD_FRAME_DIV - 1);
	wire [4:0] phase_d = phase_end ? 5'h00 : phase_q + 5'h01;
	// Each common gets an equal share of the 24 ticks
	wire [1:0] com_d   = 2'(phase_d / 5'(`LCD_FRAME_DIV / `LCD_COM_COUNT));

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			div_q <= '0;
		end else begin
			div_q <= int_tick ? '0 : div_q + DIV_W'(1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			phase_q      <= '0;
			com_idx_q    <= '0;
			frame_tick_o <= 1'b0;
		end else begin
			frame_tick_o <= osc_tick & phase_end;
			if (osc_tick) begin
				phase_q   <= phase_d;
				com_idx_q <= com_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// Segment and common outputs
	// ----------------------------------------------------------------
	// Blanking gates the outputs only, so unblank restores the old picture
	wire [SEG_COUNT-1:0] seg_d = blanked_q ? '0 : seg_mem_q[com_idx_q];

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			seg_o <= '0;
			com_o <= '0;
		end else begin
			seg_o <= seg_d;
			com_o <= 4'h1 << com_idx_q;
		end
	end

	// ----------------------------------------------------------------
	// APB read path, data captured in the setup cycle
	// ----------------------------------------------------------------
	wire [63:0] seg_word = 64'(seg_mem_q[seg_line]);
	wire [31:0] stat_word = {18'h00000, last_cmd_q, 2'h0, com_idx_q, 3'h0, blanked_q};
	wire [31:0] rd_mux =
		hit_ctrl ? {31'h00000000, osc_sel_q} :
		hit_stat ? stat_word :
		hit_seg  ? (seg_hi ? seg_word[63:32] : seg_word[31:0]) :
		32'h00000000;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			prdata_o <= '0;
		end else if (setup) begin
			prdata_o <= apb_i.pwrite ? 32'h00000000 : rd_mux;
		end
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~addr_ok;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence load_cmd_s(logic [3:0] code);
		load_rise && cmd_field.code == code;
	endsequence

	sequence sclk_edge_s;
		sclk_rise && !serial_i.load && !load_prev_q;
	endsequence

	shift_on_edge_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		sclk_edge_s |=> shift_q[SHIFT_W-1] == $past(serial_i.serial_data)
			&& shift_q[SHIFT_W-2:0] == $past(shift_q[SHIFT_W-1:1]))
		else $error("serial bit not shifted in");

	seg_write_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'h2) |=> seg_mem_q[$past(cmd_field.com)] == $past(seg_field))
		else $error("segment write missed the latch");

	line_select_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'h2) && cmd_field.com == 2'h3 |=> $stable(seg_mem_q[0])
			&& $stable(seg_mem_q[1]) && $stable(seg_mem_q[2]))
		else $error("segment write touched the wrong line");

	reset_blank_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> blanked_q ##1 seg_o == '0)
		else $error("display not blank after reset");

	blank_out_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'hA) |=> blanked_q ##1 (seg_o == '0) [*3])
		else $error("blank did not clear segments");

	unblank_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'hB) |=> !blanked_q ##1 seg_o == $past(seg_mem_q[com_idx_q]))
		else $error("unblank did not restore segments");

	bad_cmd_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_rise && !is_seg_write |=> $stable(seg_mem_q))
		else $error("undefined command changed the latch");

	strobe_once_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		serial_i.load && load_prev_q |=> $stable(shift_q) && !load_rise)
		else $error("shift or execute while strobe high");

	frame_rate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		osc_tick && phase_q == 5'h17 |=> frame_tick_o && phase_q == 5'h00)
		else $error("frame tick not at 24th oscillator tick");

	blank_keep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'hA) |=> $stable(seg_mem_q))
		else $error("blank changed the latched data");

	unblank_keep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_cmd_s(4'hB) |=> $stable(seg_mem_q))
		else $error("unblank changed the latched data");

	blank_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		blanked_q |=> seg_o == '0)
		else $error("segment driven while blanked");

	seg_follow_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!blanked_q |=> seg_o == $past(seg_mem_q[com_idx_q]))
		else $error("segments do not follow the active line");

	latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!load_rise |=> $stable(seg_mem_q))
		else $error("latch changed without a strobe");

	cmd_record_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_rise |=> last_cmd_q == $past(cmd_field))
		else $error("executed command not recorded");

	bad_cmd_blank_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		load_rise && !is_blank && !is_unblank |=> $stable(blanked_q))
		else $error("blank state changed by another command");

	high_no_shift_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		serial_i.load |=> $stable(shift_q))
		else $error("shift register moved while strobe high");

	shift_idle_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!sclk_rise |=> $stable(shift_q))
		else $error("shift register moved without a clock edge");

	phase_range_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		phase_q < 5'(`LCD_FRAME_DIV))
		else $error("multiplex phase out of range");

	tick_spacing_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		frame_tick_o |=> !frame_tick_o)
		else $error("frame tick longer than one cycle");

	tick_source_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		frame_tick_o |-> $past(osc_tick && phase_end))
		else $error("frame tick without a final phase tick");

endmodule

// ### lcd_serial_command_loader_bench.sv
`timescale 1ns/1ps

module lcd_serial_command_loader_bench;
	localparam int DIV = 4;
	logic                       core_clk_i = 1'b0;
	logic                       reset_n_i  = 1'b0;
	logic                       osc_ext_i  = 1'b0;
	logic [1:0]                 osc_cnt    = 2'h0;
	lcd_loader_pkg::serial_in_t serial_i;
	lcd_loader_pkg::apb_req_t   apb_i      = '0;
	logic [31:0]                prdata_o;
	logic                       pready_o;
	logic                       pslverr_o;
	logic [39:0]                seg_o;
	logic [3:0]                 com_o;
	logic                       frame_tick_o;
	int                         miscompares = 0;
	int                         comparisons = 0;
	logic [31:0]                rd;
	logic                       err;
	logic [39:0]                pat [4];
	int                         i;

	always #4 core_clk_i = ~core_clk_i;

	// External oscillator, period of eight core cycles
	always @(posedge core_clk_i) begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3) begin
			osc_ext_i <= ~osc_ext_i;
		end
	end

	lcd_host_link_model i_host (.core_clk_i(core_clk_i), .serial_o(serial_i));

	lcd_serial_command_loader #(.OSC_DIV(DIV)) i_dut (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.serial_i    (serial_i),
		.osc_ext_i   (osc_ext_i),
		.apb_i       (apb_i),
		.prdata_o    (prdata_o),
		.pready_o    (pready_o),
		.pslverr_o   (pslverr_o),
		.seg_o       (seg_o),
		.com_o       (com_o),
		.frame_tick_o(frame_tick_o)
	);

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk_i);
		apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge core_clk_i);
		apb_i.penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk_i);
			if (pready_o === 1'b1) break;
		end
		if (k == 50) begin
			miscompares++;
			tally_and_finish();
		end
		rd = prdata_o;
		err = pslverr_o;
		apb_i <= '0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [39:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk({8'h00, rd}, exp);
	endtask

	// Samples the segments two cycles into the given line's slot
	task automatic seg_chk(input int n, input logic [39:0] exp);
		int k;
		// Wait for the slot to start, so the sample cannot fall past its end
		for (k = 0; k < 1000 && com_o === 4'(1 << n); k++) @(posedge core_clk_i);
		for (k = k; k < 1000 && com_o !== 4'(1 << n); k++) @(posedge core_clk_i);
		if (k == 1000) begin
			miscompares++;
			tally_and_finish();
		end
		repeat (2) @(posedge core_clk_i);
		chk(seg_o, exp);
	endtask

	task automatic tick_gap(input int exp);
		int k;
		int c;
		for (k = 0; k < 2000 && frame_tick_o !== 1'b1; k++) @(posedge core_clk_i);
		@(posedge core_clk_i);
		for (c = 1; c < 2000 && frame_tick_o !== 1'b1; c++) @(posedge core_clk_i);
		if (k == 2000 || c == 2000) begin
			miscompares++;
			tally_and_finish();
		end
		chk(40'(c), 40'(exp));
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i);
		@(posedge core_clk_i);
		chk(seg_o, 40'h00_0000_0000);
		rd_chk(12'h004, 40'h1);
		rd_chk(12'h000, 40'h0);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			pat[i] = {8'hC0 + 8'(i), 32'h1234_5678 ^ (32'h1111_1111 * i)};
			i_host.send({4'h2, 2'(i), pat[i]}, 0, (i == 3) ? 2 : 0, 0);
			rd_chk(12'(12'h010 + 8 * i), {8'h00, pat[i][31:0]});
			rd_chk(12'(12'h014 + 8 * i), {32'h0, pat[i][39:32]});
		end
		chk(seg_o, 40'h00_0000_0000);
		$display("test segment write done");
		i_host.send({4'hB, 42'h0}, 42, 0, 0);
		apb(1'b0, 12'h004, 32'h0);
		// Low line bits are the old code bits moved down by four shifts
		chk(40'({rd[13:8], rd[0]}), 40'({6'h2C, 1'b0}));
		for (i = 0; i < 4; i++) seg_chk(i, pat[i]);
		i_host.send({4'hA, 42'h0}, 42, 0, 0);
		seg_chk(2, 40'h00_0000_0000);
		rd_chk(12'h020, {8'h00, pat[2][31:0]});
		i_host.send({4'hB, 42'h0}, 42, 0, 0);
		seg_chk(2, pat[2]);
		$display("test blank done");
		for (i = 0; i < 16; i++) begin
			if (i == 2 || i == 10 || i == 11) continue;
			i_host.send({4'(i), 2'h1, ~pat[1]}, 0, 0, 0);
			rd_chk(12'h018, {8'h00, pat[1][31:0]});
			rd_chk(12'h01C, {32'h0, pat[1][39:32]});
			apb(1'b0, 12'h004, 32'h0);
			chk(40'(rd[13:8]), 40'({4'(i), 2'h1}));
		end
		i_host.send({4'h2, 2'h1, ~pat[1]}, 0, 0, 0);
		rd_chk(12'h018, {8'h00, ~pat[1][31:0]});
		$display("test undefined done");
		i_host.send({4'h2, 2'h1, pat[1]}, 0, 0, 3);
		i_host.send(46'h0, 46, 0, 0);
		apb(1'b0, 12'h004, 32'h0);
		chk(40'(rd[13:8]), 40'h09);
		rd_chk(12'h018, {8'h00, pat[1][31:0]});
		$display("test strobe lockout done");
		tick_gap(24 * DIV);
		apb(1'b1, 12'h000, 32'h0000_0001);
		rd_chk(12'h000, 40'h1);
		tick_gap(24 * 8);
		apb(1'b0, 12'h800, 32'h0);
		chk({39'h0, err}, 40'h1);
		chk({8'h00, rd}, 40'h0);
		$display("test frame rate done");
		reset_n_i <= 1'b0;
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i);
		@(posedge core_clk_i);
		chk(seg_o, 40'h00_0000_0000);
		apb(1'b0, 12'h004, 32'h0);
		chk(40'({rd[13:8], rd[0]}), 40'h01);
		rd_chk(12'h018, 40'h0);
		$display("test reset again done");
		tally_and_finish();
	end
endmodule
